// *** logic/cts_pkg.sv ***
// Constants, state encoding and carrier types for the machine-cycle timing block.
// Assumes one core clock with a near even duty cycle; both its edges are used.
package cts_pkg;
	localparam int CTS_CLK_PERIOD_NS = 50;
	localparam int CTS_STATE_TIME_NS = 50;
	localparam int CTS_CLKS_PER_STATE = (CTS_STATE_TIME_NS + CTS_CLK_PERIOD_NS - 1) / CTS_CLK_PERIOD_NS;
	localparam int CTS_STRETCH_LSB = 0;
	localparam int CTS_STRETCH_MSB = 2;
	localparam logic [7:0] CTS_CCR_RESET = 8'h01;
	localparam logic [2:0] CTS_STRETCH_ZERO = 3'h0;
	localparam logic [3:0] CTS_MC_ZERO = 4'h0;
	localparam logic [3:0] CTS_MC_ONE = 4'h1;
	localparam logic [7:0] CTS_OP_COMPARE_JUMP_UNEQUAL_FIRST = 8'hB4;
	localparam logic [7:0] CTS_OP_COMPARE_JUMP_UNEQUAL_LAST = 8'hBF;
	localparam logic [7:0] CTS_OP_XRD_DPTR = 8'hE0;
	localparam logic [7:0] CTS_OP_XRD_R0 = 8'hE2;
	localparam logic [7:0] CTS_OP_XRD_R1 = 8'hE3;
	localparam logic [7:0] CTS_OP_XWR_DPTR = 8'hF0;
	localparam logic [7:0] CTS_OP_XWR_R0 = 8'hF2;
	localparam logic [7:0] CTS_OP_XWR_R1 = 8'hF3;

	typedef enum logic [1:0]
	{
		CTS_STATE_ONE = 2'h0,
		CTS_STATE_TWO = 2'h1,
		CTS_STATE_THREE = 2'h3,
		CTS_STATE_FOUR = 2'h2
	} cts_state_t;

	typedef struct packed
	{
		cts_state_t state;
		cts_state_t state_late;
		logic cycle_end;
		logic fetch;
		logic core_hold;
	} cts_timing_t;

	typedef struct packed
	{
		logic addr_drive;
		logic rd_n;
		logic wr_n;
	} cts_xmem_t;
endpackage : cts_pkg

// *** logic/cts_cycle_timing.sv ***
// Machine-cycle sequencer, instruction length decoder and external data move stretcher.
// Assumes the core presents each new opcode with a valid flag from the same clock domain.
`timescale 1ns/1ps

// Notes on behaviour
// [RULE1] Four one-clock states per machine cycle, fixed order.
// [RULE2] At most one opcode byte fetched per cycle.
// [RULE3] Decoder covers all 256 opcodes, 133 single-cycle.
// [RULE4] Non-move instructions take one to five cycles.
// [RULE5] Internal state clocked on both clock edges.
// [RULE6] Move starts with fetch, then address and access.
// [RULE7] Stretch field bits 2..0 give 2..9 cycles.
// [RULE8] Stretch resets to one, three cycles.
// [RULE9] Strobe width 2, 4, 8, then plus four.
// [RULE10] Strobes widen with the added move cycles.
// [RULE11] Stretch affects moves only; core frozen meanwhile.
// [RULE12] Compare-jump B4..BF: three bytes, four cycles.
// [RULE13] Stretch sampled at move start, held throughout.
module cts_cycle_timing
(
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	input wire logic clk_en_i,
	input wire logic [7:0] opcode_i,
	input wire logic opcode_valid_i,
	input wire logic ccr_wr_i,
	input wire logic [7:0] ccr_data_i,
	output logic [7:0] ccr_o,
	output cts_pkg::cts_timing_t timing_o,
	output cts_pkg::cts_xmem_t xmem_o
);
	import cts_pkg::*;

	cts_state_t state;
	cts_state_t next_state;
	cts_state_t state_late;
	logic [7:0] cycle_control_register;
	logic [3:0] mc_left;
	logic [3:0] next_mc_left;
	logic [1:0] bytes_left;
	logic [1:0] next_bytes_left;
	logic in_move;
	logic next_in_move;
	logic move_write;
	logic next_move_write;
	logic [2:0] move_stretch;
	logic [2:0] next_move_stretch;
	logic [3:0] acc_idx;
	logic [3:0] next_acc_idx;
	logic new_instr;
	logic is_move;
	logic cycle_end;
	logic fetch_cycle;
	logic core_hold;

	function automatic cts_state_t step_state(input cts_state_t s);
		case (s)
			CTS_STATE_ONE: step_state = CTS_STATE_TWO;
			CTS_STATE_TWO: step_state = CTS_STATE_THREE;
			CTS_STATE_THREE: step_state = CTS_STATE_FOUR;
			CTS_STATE_FOUR: step_state = CTS_STATE_ONE;
			default: step_state = CTS_STATE_ONE;
		endcase
	endfunction : step_state

	// Byte count of each opcode, grouped by the low nibble of the opcode map.
	function automatic logic [1:0] bytes_of(input logic [7:0] op);
		logic [1:0] n;
		n = 2'h1;
		if (op[3])
		begin
			case (op[7:4])
				4'h7, 4'h8, 4'hA, 4'hD: n = 2'h2;
				4'hB: n = 2'h3;
				default: n = 2'h1;
			endcase
		end
		else
		begin
			case (op[2:0])
				3'h0:
				begin
					case (op[7:4])
						4'h0, 4'hE, 4'hF: n = 2'h1;
						4'h1, 4'h2, 4'h3, 4'h9: n = 2'h3;
						default: n = 2'h2;
					endcase
				end
				3'h1: n = 2'h2;
				3'h2:
				begin
					case (op[7:4])
						4'h0, 4'h1: n = 2'h3;
						4'h2, 4'h3, 4'hE, 4'hF: n = 2'h1;
						default: n = 2'h2;
					endcase
				end
				3'h3:
				begin
					case (op[7:4])
						4'h4, 4'h5, 4'h6: n = 2'h3;
						default: n = 2'h1;
					endcase
				end
				3'h4:
				begin
					case (op[7:4])
						4'h0, 4'h1, 4'h8, 4'hA, 4'hC, 4'hD, 4'hE, 4'hF: n = 2'h1;
						4'hB: n = 2'h3;
						default: n = 2'h2;
					endcase
				end
				3'h5:
				begin
					case (op[7:4])
						4'h8, 4'hB, 4'hD: n = 2'h3;
						default: n = 2'h2;
					endcase
				end
				default:
				begin
					case (op[7:4])
						4'h7, 4'h8, 4'hA: n = 2'h2;
						4'hB: n = 2'h3;
						default: n = 2'h1;
					endcase
				end
			endcase
		end
		bytes_of = n;
	endfunction : bytes_of

	// Machine cycles of every non-move opcode; most equal the byte count.
	function automatic logic [3:0] cycles_of(input logic [7:0] op);
		logic [3:0] c;
		c = {2'h0, bytes_of(op)}; // [RULE3]
		if (op >= CTS_OP_COMPARE_JUMP_UNEQUAL_FIRST && op <= CTS_OP_COMPARE_JUMP_UNEQUAL_LAST)
			c = 4'h4; // [RULE12]
		else if (op[3:0] == 4'h1)
			c = 4'h3;
		else
		begin
			case (op)
				8'h02, 8'h12, 8'h10, 8'h20, 8'h30, 8'hD5: c = 4'h4;
				8'h22, 8'h32, 8'h73, 8'h83, 8'h93: c = 4'h2;
				8'h40, 8'h50, 8'h60, 8'h70, 8'h80: c = 4'h3;
				8'hD8, 8'hD9, 8'hDA, 8'hDB, 8'hDC, 8'hDD, 8'hDE, 8'hDF: c = 4'h3;
				8'h84, 8'hA4: c = 4'h5;
				default: c = {2'h0, bytes_of(op)};
			endcase
		end
		cycles_of = c; // [RULE4]
	endfunction : cycles_of

	function automatic logic move_op(input logic [7:0] op);
		move_op = (op == CTS_OP_XRD_DPTR) || (op == CTS_OP_XRD_R0) || (op == CTS_OP_XRD_R1)
			|| (op == CTS_OP_XWR_DPTR) || (op == CTS_OP_XWR_R0) || (op == CTS_OP_XWR_R1);
	endfunction : move_op

	// Strobe is low for two clocks unstretched, else four clocks per stretch step.
	function automatic logic strobe_on(input logic mv, input logic [2:0] st,
		input logic [3:0] idx, input cts_state_t s);
		if (!mv)
			strobe_on = 1'b0;
		else if (st == CTS_STRETCH_ZERO)
			strobe_on = (idx == CTS_MC_ZERO) && (s == CTS_STATE_TWO || s == CTS_STATE_THREE); // [RULE9]
		else
			strobe_on = (idx >= CTS_MC_ONE) && (idx <= {1'b0, st}); // [RULE10]
	endfunction : strobe_on

	assign new_instr = (mc_left == CTS_MC_ZERO) && !in_move;
	assign is_move = move_op(opcode_i);

	always_comb
	begin
		next_state = step_state(state); // [RULE1]
		next_mc_left = mc_left;
		next_bytes_left = bytes_left;
		next_in_move = in_move;
		next_move_write = move_write;
		next_move_stretch = move_stretch;
		next_acc_idx = acc_idx;
		if (state == CTS_STATE_FOUR)
		begin
			if (in_move)
			begin
				// The access phase spans stretch plus one cycles after the fetch.
				if (acc_idx == {1'b0, move_stretch})
				begin
					next_in_move = 1'b0;
					next_acc_idx = CTS_MC_ZERO;
				end
				else
					next_acc_idx = acc_idx + CTS_MC_ONE;
			end
			else if (new_instr && opcode_valid_i)
			begin
				if (is_move)
				begin
					next_in_move = 1'b1; // [RULE6]
					next_move_write = opcode_i[4];
					next_move_stretch = cycle_control_register[CTS_STRETCH_MSB:CTS_STRETCH_LSB]; // [RULE13]
					next_acc_idx = CTS_MC_ZERO;
				end
				else
				begin
					next_mc_left = cycles_of(opcode_i) - CTS_MC_ONE;
					next_bytes_left = bytes_of(opcode_i) - 2'h1; // [RULE2]
				end
			end
			else if (mc_left != CTS_MC_ZERO)
			begin
				next_mc_left = mc_left - CTS_MC_ONE;
				if (bytes_left != 2'h0)
					next_bytes_left = bytes_left - 2'h1;
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			state <= CTS_STATE_ONE;
		else if (clk_en_i)
			state <= next_state; // [RULE1]
	end

	// A falling-edge copy of the state gives half-state resolution to the core.
	always_ff @(negedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			state_late <= CTS_STATE_ONE;
		else if (clk_en_i)
			state_late <= state; // [RULE5]
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			cycle_control_register <= CTS_CCR_RESET; // [RULE8]
		else if (clk_en_i && ccr_wr_i)
			cycle_control_register <= ccr_data_i; // [RULE7]
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			mc_left <= CTS_MC_ZERO;
			bytes_left <= 2'h0;
		end
		else if (clk_en_i)
		begin
			mc_left <= next_mc_left;
			bytes_left <= next_bytes_left;
		end
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			in_move <= 1'b0;
			move_write <= 1'b0;
			move_stretch <= CTS_STRETCH_ZERO;
			acc_idx <= CTS_MC_ZERO;
		end
		else if (clk_en_i)
		begin
			in_move <= next_in_move;
			move_write <= next_move_write;
			move_stretch <= next_move_stretch;
			acc_idx <= next_acc_idx;
		end
	end

	// Outputs are registered from the next values so they align with the state they describe.
	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			cycle_end <= 1'b0;
			fetch_cycle <= 1'b1;
			core_hold <= 1'b0;
		end
		else if (clk_en_i)
		begin
			cycle_end <= (next_state == CTS_STATE_FOUR);
			fetch_cycle <= ((next_mc_left == CTS_MC_ZERO) && !next_in_move)
				|| (next_bytes_left != 2'h0); // [RULE2]
			// Only cycles beyond the normal two-cycle move freeze the core.
			core_hold <= next_in_move && (next_acc_idx >= CTS_MC_ONE); // [RULE11]
		end
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			xmem_o.addr_drive <= 1'b0;
			xmem_o.rd_n <= 1'b1;
			xmem_o.wr_n <= 1'b1;
		end
		else if (clk_en_i)
		begin
			xmem_o.addr_drive <= next_in_move; // [RULE6]
			xmem_o.rd_n <= !(strobe_on(next_in_move, next_move_stretch, next_acc_idx, next_state)
				&& !next_move_write); // [RULE9]
			xmem_o.wr_n <= !(strobe_on(next_in_move, next_move_stretch, next_acc_idx, next_state)
				&& next_move_write); // [RULE10]
		end
	end

	// The carrier has one driver; its fields come from registers of both clock edges.
	assign timing_o = '{state: state, state_late: state_late, cycle_end: cycle_end,
		fetch: fetch_cycle, core_hold: core_hold};
	assign ccr_o = cycle_control_register;
endmodule : cts_cycle_timing

// *** dv/cts_cycle_timing_props.sv ***
// Assertion checker for the machine-cycle timing block.
// Assumes it is bound to cts_cycle_timing and sees only that module's ports.
`timescale 1ns/1ps
module cts_props
(
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	input wire logic clk_en_i,
	input wire logic ccr_wr_i,
	input wire logic [7:0] ccr_data_i,
	input wire logic [7:0] ccr_o,
	input wire cts_pkg::cts_timing_t timing_o,
	input wire cts_pkg::cts_xmem_t xmem_o
);
	import cts_pkg::*;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!arst_n_i);
	// Reset is sampled in the antecedents, since a release on a clock edge would otherwise
	// start an attempt at the very edge the block still spends in reset.
	property p_one_two;
		arst_n_i && clk_en_i && timing_o.state == CTS_STATE_ONE
			|=> timing_o.state == CTS_STATE_TWO;
	endproperty
	a_one_two: assert property (p_one_two) else $error("state one not followed by two");
	property p_four_one;
		arst_n_i && clk_en_i && timing_o.state == CTS_STATE_FOUR
			|=> timing_o.state == CTS_STATE_ONE;
	endproperty
	a_four_one: assert property (p_four_one) else $error("state four not followed by one");
	property p_end;
		timing_o.cycle_end == (timing_o.state == CTS_STATE_FOUR);
	endproperty
	a_end: assert property (p_end) else $error("cycle end flag off state four");
	property p_freeze;
		!clk_en_i |=> $stable(timing_o);
	endproperty
	a_freeze: assert property (p_freeze) else $error("timing moved while disabled");
	property p_late;
		clk_en_i |-> timing_o.state_late == timing_o.state;
	endproperty
	a_late: assert property (p_late) else $error("falling edge copy of state lags");
	property p_ccr;
		arst_n_i && clk_en_i && ccr_wr_i |=> ccr_o == $past(ccr_data_i);
	endproperty
	a_ccr: assert property (p_ccr) else $error("control register write lost");
	property p_one_strobe;
		xmem_o.rd_n || xmem_o.wr_n;
	endproperty
	a_one_strobe: assert property (p_one_strobe) else $error("both strobes low");
	property p_strobe_addr;
		!(xmem_o.rd_n && xmem_o.wr_n) |-> xmem_o.addr_drive && !timing_o.fetch;
	endproperty
	a_strobe_addr: assert property (p_strobe_addr) else $error("strobe outside access cycles");
	property p_fetch_move;
		xmem_o.addr_drive |-> !timing_o.fetch;
	endproperty
	a_fetch_move: assert property (p_fetch_move) else $error("fetch during an access cycle");
	property p_hold_addr;
		timing_o.core_hold |-> xmem_o.addr_drive;
	endproperty
	a_hold_addr: assert property (p_hold_addr) else $error("hold outside a move");
	property p_hold_first;
		$rose(xmem_o.addr_drive) |-> !timing_o.core_hold [*4];
	endproperty
	a_hold_first: assert property (p_hold_first) else $error("core held in first access cycle");
	property p_min_w;
		$fell(xmem_o.rd_n && xmem_o.wr_n) |-> !(xmem_o.rd_n && xmem_o.wr_n) [*2];
	endproperty
	a_min_w: assert property (p_min_w) else $error("strobe shorter than two clocks");
	property p_addr_len;
		$rose(xmem_o.addr_drive) |-> xmem_o.addr_drive [*4];
	endproperty
	a_addr_len: assert property (p_addr_len) else $error("access shorter than a cycle");
endmodule : cts_props
bind cts_cycle_timing cts_props u_props (.clk_sys_i, .arst_n_i, .clk_en_i, .ccr_wr_i, .ccr_data_i,
	.ccr_o, .timing_o, .xmem_o);

// *** dv/cts_xmem_model.sv ***
// Behavioural external data memory that measures each strobe pulse it receives.
// Assumes active-low strobes sampled on the core clock; it drives no data back.
`timescale 1ns/1ps
module cts_xmem_model
(
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	input wire cts_pkg::cts_xmem_t xmem_i,
	output logic [7:0] width_o
);
	import cts_pkg::*;
	logic [7:0] run;
	// The width is published only once the strobe has ended, so a read mid-pulse sees the last.
	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			run <= 8'h00;
			width_o <= 8'h00;
		end
		else if (!(xmem_i.rd_n && xmem_i.wr_n))
			run <= run + 8'h01;
		else if (run != 8'h00)
		begin
			width_o <= run;
			run <= 8'h00;
		end
	end
endmodule : cts_xmem_model

// *** dv/cts_tb.sv ***
// Self-checking bench for the machine-cycle timing block with a strobe-measuring memory.
// Assumes a 20 MHz core clock; every scenario restarts the block from reset.
`timescale 1ns/1ps
module tb;
	import cts_pkg::*;
	logic clk_sys_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic clk_en_i = 1'b1;
	logic [7:0] opcode_i = 8'h00;
	logic opcode_valid_i = 1'b0;
	logic ccr_wr_i = 1'b0;
	logic [7:0] ccr_data_i = 8'h00;
	logic [7:0] ccr_o;
	cts_timing_t timing_o;
	cts_xmem_t xmem_o;
	logic [7:0] width;
	int failures = 0;
	int cmp_count = 0;
	int cycles = 0;
	logic [7:0] ops [12] = '{8'hB4, 8'hBF, 8'hB6, 8'hD8, 8'hDF, 8'hD5, 8'h10, 8'hC3, 8'hC5, 8'h80,
		8'h12, 8'h84};
	logic [7:0] movs [6] = '{8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3};
	always #25 clk_sys_i = ~clk_sys_i;
	cts_cycle_timing dut (.clk_sys_i, .arst_n_i, .clk_en_i, .opcode_i, .opcode_valid_i, .ccr_wr_i,
		.ccr_data_i, .ccr_o, .timing_o, .xmem_o);
	cts_xmem_model u_mem (.clk_sys_i, .arst_n_i, .xmem_i(xmem_o), .width_o(width));
	// Zero means the opcode's cycle count is not pinned down, only its range.
	function automatic logic [7:0] exp_cyc(input logic [7:0] op);
		if (op inside {[8'hB4:8'hBF], 8'hD5, 8'h10, 8'h12}) return 8'h04;
		if (op inside {[8'hD8:8'hDF], 8'h80}) return 8'h03;
		if (op == 8'hC5) return 8'h02;
		if (op == 8'h84) return 8'h05;
		if (op == 8'hC3) return 8'h01;
		return 8'h00;
	endfunction : exp_cyc
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			failures++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic tally_and_finish;
		$display("compares=%0d mismatches=%0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : tally_and_finish
	task automatic run(input logic [7:0] op, input logic [2:0] s, input logic [7:0] mop);
		logic [7:0] k;
		logic [7:0] bad;
		logic [7:0] d;
		logic [7:0] hold;
		k = 8'h00;
		bad = 8'h00;
		hold = 8'h00;
		d = {5'($urandom), s};
		@(posedge clk_sys_i);
		arst_n_i <= 1'b0;
		opcode_i <= op;
		opcode_valid_i <= 1'b1;
		ccr_wr_i <= 1'b1;
		ccr_data_i <= d;
		@(posedge clk_sys_i);
		#1 check(ccr_o, CTS_CCR_RESET);
		@(posedge clk_sys_i);
		arst_n_i <= 1'b1;
		@(posedge clk_sys_i);
		ccr_wr_i <= 1'b0;
		repeat (3) @(posedge clk_sys_i);
		opcode_i <= mop;
		#1 check(ccr_o, d);
		while (xmem_o.addr_drive !== 1'b1 && k < 8'd60)
		begin
			@(posedge clk_sys_i);
			#1 k++;
		end
		if (exp_cyc(op) != 8'h00)
			check(k, 8'(4 * exp_cyc(op)));
		else
			check({7'h00, k[1:0] == 2'h0 && k >= 4 && k <= 20}, 8'h01);
		// A write lands mid-move; the move must keep the length sampled at its start.
		// Counting starts at the edge that raised the address drive, so it ends at the clock total.
		k = 8'h00;
		while (xmem_o.addr_drive === 1'b1 && k < 8'd60)
		begin
			if ((mop[4] ? xmem_o.rd_n : xmem_o.wr_n) !== 1'b1) bad++;
			if (timing_o.core_hold === 1'b1) hold++;
			@(posedge clk_sys_i);
			ccr_wr_i <= (k == 8'h01);
			ccr_data_i <= ~d;
			#1 k++;
		end
		check(k, 8'(4 * s + 4));
		check(hold, 8'(4 * s));
		check(bad, 8'h00);
		@(posedge clk_sys_i);
		opcode_valid_i <= 1'b0;
		#1 check(width, s == 3'h0 ? 8'h02 : 8'({s, 2'b00}));
		check(ccr_o, ~d);
	endtask : run
	initial
	begin
		logic [7:0] op;
		logic [2:0] s;
		void'($urandom(32'h19c9fe90));
		repeat (20) @(posedge clk_sys_i);
		arst_n_i <= 1'b1;
		clk_en_i <= 1'b0;
		repeat (3) @(posedge clk_sys_i);
		clk_en_i <= 1'b1;
		#1 check({6'h00, timing_o.state}, {6'h00, CTS_STATE_ONE});
		for (int i = 0; i < 40; i++)
		begin
			op = (i < 12) ? ops[i] : 8'($urandom);
			if (op inside {movs}) op = 8'hC3;
			s = (i < 12) ? 3'(i) : 3'($urandom);
			run(op, s, movs[$urandom % 6]);
		end
		tally_and_finish();
	end
	always @(posedge clk_sys_i)
	begin
		cycles <= cycles + 1;
		if (cycles == 10000)
		begin
			failures++;
			tally_and_finish();
		end
	end
endmodule : tb
